// ===== rtl/gpb_pkg.sv
// global parameter bank package: parameter numbers, reset values, cycle counts.
// assumes a 125 MHz core clock; used by gpb_global_param_bank and its assertions checker.
package gpb_pkg;
  // parameter banks
  localparam logic [1:0] BANK_GLOBAL = 2'h0;
  localparam logic [1:0] BANK_USER = 2'h2;
  localparam logic [1:0] BANK_IRQ = 2'h3;
  // bank 0 numbers
  localparam logic [7:0] P_AUTORUN = 8'h4d;
  localparam logic [7:0] P_PROTECT = 8'h51;
  localparam logic [7:0] P_CAN_WD = 8'h52;
  localparam logic [7:0] P_CAN_ALT = 8'h53;
  localparam logic [7:0] P_COORD = 8'h54;
  localparam logic [7:0] P_NORESTORE = 8'h55;
  localparam logic [7:0] P_SER_ALT = 8'h57;
  localparam logic [7:0] P_RUN_STATE = 8'h80;
  localparam logic [7:0] P_LOAD_STATE = 8'h81;
  localparam logic [7:0] P_IPTR = 8'h82;
  localparam logic [7:0] P_MS_CNT = 8'h84;
  localparam logic [7:0] P_RANDOM = 8'h85;
  localparam logic [7:0] P_MUTE = 8'hff;
  // bank 3 numbers
  localparam logic [7:0] P_TMR0 = 8'h00;
  localparam logic [7:0] P_TMR1 = 8'h01;
  localparam logic [7:0] P_TMR2 = 8'h02;
  localparam logic [7:0] P_STOPL = 8'h1b;
  localparam logic [7:0] P_STOPR = 8'h1c;
  localparam logic [7:0] P_IN0 = 8'h27;
  localparam logic [7:0] P_IN1 = 8'h28;
  localparam logic [7:0] P_IN2 = 8'h29;
  // user variable total and last persistent variable number
  localparam int USER_VARS = 256;
  localparam logic [7:0] USER_NV_LAST = 8'h37;
  // field widths / maxima
  localparam logic [10:0] CAN_ID_MAX = 11'h7ff;
  localparam logic [30:0] RANDOM_MASK = 31'h7fff_ffff;
  localparam logic [31:0] SEED_RESET = 32'h0000_0001;
  // millisecond tick: 1 ms at 125 MHz
  localparam int CLK_KHZ = 125000;
  localparam int MS_CYCLES = CLK_KHZ;
  localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);
  // edge select codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // protection bit positions
  localparam int PROT_DISASM_BIT = 0;
  localparam int PROT_WRITE_BIT = 1;
  // commands seen by the reply gate
  localparam logic [7:0] CMD_AXIS_READ = 8'h06;
  localparam logic [7:0] CMD_GLOBAL_READ = 8'h0a;
  localparam logic [7:0] CMD_IO_READ = 8'h0f;
  // startup sequencer
  typedef enum logic [1:0] {GPB_BOOT, GPB_RESTORE, GPB_RUN} gpb_boot_t;
endpackage

// ===== rtl/gpb_global_param_bank.sv
// global parameter bank: parameter read/write port, user variables, timers,
// edge interrupts, watchdog and startup control for the module firmware.
// assumes parameter requests arrive as one-cycle strobes synchronous to core_clk.
`timescale 1ns/10ps
module gpb_global_param_bank (
  input wire logic core_clk,
  input wire logic rst_n,
  // parameter port
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_bank,
  input wire logic [7:0] req_num,
  input wire logic [31:0] req_wdata,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  output logic rsp_error,
  // command monitor for reply gating and watchdog
  input wire logic cmd_valid,
  input wire logic cmd_from_can,
  input wire logic [7:0] cmd_opcode,
  output logic reply_enable,
  // address match
  input wire logic [10:0] can_rx_id,
  input wire logic [7:0] ser_rx_addr,
  output logic can_alt_hit,
  output logic ser_alt_hit,
  // program engine status
  input wire logic [1:0] run_state_in,
  input wire logic load_state_in,
  input wire logic [31:0] iptr_in,
  output logic program_start,
  output logic program_erase,
  output logic [1:0] protection,
  output logic motor_stop,
  output logic coord_persist,
  // nonvolatile store
  input wire logic nv_ready,
  input wire logic [31:0] nv_rdata,
  output logic nv_wr,
  output logic nv_rd,
  output logic [7:0] nv_addr,
  output logic [31:0] nv_wdata,
  // interrupt sources and request
  input wire logic stop_left,
  input wire logic stop_right,
  input wire logic [2:0] gp_in,
  output logic irq_valid,
  output logic [7:0] irq_num
);
  // reset release through two flops
  logic rst_q1, rst_sync_n;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_q1 <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_sync_n <= rst_q1;
    end
  end

  logic wr_g, wr_u, wr_i; // write strobes per bank
  assign wr_g = req_valid && req_write && req_bank == gpb_pkg::BANK_GLOBAL;
  assign wr_u = req_valid && req_write && req_bank == gpb_pkg::BANK_USER;
  assign wr_i = req_valid && req_write && req_bank == gpb_pkg::BANK_IRQ;

  // writable global settings
  logic autorun, norestore, mute;
  logic [15:0] can_wd;
  logic [10:0] can_alt;
  logic [7:0] ser_alt;
  logic [31:0] ms_cnt;
  logic [31:0] seed;
  logic [16:0] ms_div;
  logic ms_tick;
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      autorun <= 1'b0;
      norestore <= 1'b0;
      mute <= 1'b0; // never persisted, zero on every start
      can_wd <= 16'h0000;
      can_alt <= 11'h000;
      ser_alt <= 8'h00;
      protection <= 2'h0;
      coord_persist <= 1'b0;
    end
    else if (wr_g)
    begin
      case (req_num)
        gpb_pkg::P_AUTORUN: autorun <= req_wdata[0];
        gpb_pkg::P_PROTECT: protection <= req_wdata[1:0];
        gpb_pkg::P_CAN_WD: can_wd <= req_wdata[15:0];
        gpb_pkg::P_CAN_ALT: can_alt <= req_wdata[10:0];
        gpb_pkg::P_COORD: coord_persist <= req_wdata[0];
        gpb_pkg::P_NORESTORE: norestore <= req_wdata[0];
        gpb_pkg::P_SER_ALT: ser_alt <= req_wdata[7:0];
        gpb_pkg::P_MUTE: mute <= req_wdata[0];
        default: ; // read-only or unknown numbers store nothing
      endcase
    end
  end

  // erase pulse when disassembly protection is dropped; the new code is stored
  // in the same edge, so erase is requested in the cycle the new setting appears
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      program_erase <= 1'b0;
    else
      program_erase <= wr_g && req_num == gpb_pkg::P_PROTECT
        && protection[gpb_pkg::PROT_DISASM_BIT]
        && !req_wdata[gpb_pkg::PROT_DISASM_BIT];
  end

  // millisecond prescaler
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      ms_div <= 17'h0_0000;
    else if (ms_div == gpb_pkg::MS_LAST)
      ms_div <= 17'h0_0000;
    else
      ms_div <= ms_div + 17'h0_0001;
  end
  assign ms_tick = ms_div == gpb_pkg::MS_LAST;

  // tick counter; a write wins over the tick
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      ms_cnt <= 32'h0000_0000;
    else if (wr_g && req_num == gpb_pkg::P_MS_CNT)
      ms_cnt <= req_wdata;
    else if (ms_tick)
      ms_cnt <= ms_cnt + 32'h0000_0001;
  end

  // 32-bit galois lfsr; a zero seed would lock it, so it is forced to one
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      seed <= gpb_pkg::SEED_RESET;
    else if (wr_g && req_num == gpb_pkg::P_RANDOM)
      seed <= (req_wdata == 32'h0000_0000) ? gpb_pkg::SEED_RESET : req_wdata;
    else
      seed <= {1'b0, seed[31:1]} ^ (seed[0] ? 32'h8020_0003 : 32'h0000_0000);
  end

  // can watchdog, restarted by each valid can command
  logic [15:0] wd_ms;
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      wd_ms <= 16'h0000;
      motor_stop <= 1'b0;
    end
    else if (can_wd == 16'h0000)
    begin
      wd_ms <= 16'h0000; // supervision off
      motor_stop <= 1'b0;
    end
    else if (cmd_valid && cmd_from_can)
    begin
      wd_ms <= 16'h0000;
      motor_stop <= 1'b0;
    end
    else if (ms_tick && wd_ms != can_wd)
      wd_ms <= wd_ms + 16'h0001;
    else if (wd_ms == can_wd)
      motor_stop <= 1'b1;
  end

  // reply gating and alternate address matching
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      reply_enable <= 1'b1;
      can_alt_hit <= 1'b0;
      ser_alt_hit <= 1'b0;
    end
    else
    begin
      reply_enable <= !mute || cmd_opcode == gpb_pkg::CMD_AXIS_READ
        || cmd_opcode == gpb_pkg::CMD_GLOBAL_READ
        || cmd_opcode == gpb_pkg::CMD_IO_READ;
      can_alt_hit <= can_alt != 11'h000 && can_rx_id == can_alt;
      ser_alt_hit <= ser_alt != 8'h00 && ser_rx_addr == ser_alt;
    end
  end

  // user variables; volatile array, first 56 mirrored to nonvolatile
  logic [31:0] uvar [gpb_pkg::USER_VARS];
  gpb_pkg::gpb_boot_t boot;
  logic [7:0] rst_idx;
  logic rd_pend;
  always_ff @(posedge core_clk)
  begin
    if (boot == gpb_pkg::GPB_RESTORE && nv_ready && rd_pend)
      uvar[rst_idx] <= nv_rdata;
    else if (wr_u)
      uvar[req_num] <= req_wdata;
  end

  // startup: restore variables (norestore resets to zero, so never inhibited), then maybe autorun
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      boot <= gpb_pkg::GPB_BOOT;
      rst_idx <= 8'h00;
      rd_pend <= 1'b0;
      program_start <= 1'b0;
    end
    else
    begin
      program_start <= 1'b0;
      case (boot)
        gpb_pkg::GPB_BOOT:
        begin
          boot <= norestore ? gpb_pkg::GPB_RUN : gpb_pkg::GPB_RESTORE;
          program_start <= norestore && autorun;
        end
        gpb_pkg::GPB_RESTORE:
        begin
          rd_pend <= 1'b1;
          if (nv_ready && rd_pend)
          begin
            rd_pend <= 1'b0;
            if (rst_idx == gpb_pkg::USER_NV_LAST)
            begin
              boot <= gpb_pkg::GPB_RUN;
              program_start <= autorun;
            end
            else
              rst_idx <= rst_idx + 8'h01;
          end
        end
        gpb_pkg::GPB_RUN: ;
        default: boot <= gpb_pkg::GPB_BOOT;
      endcase
    end
  end

  // nonvolatile port: restore reads, persistent variable writes
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      nv_rd <= 1'b0;
      nv_wr <= 1'b0;
      nv_addr <= 8'h00;
      nv_wdata <= 32'h0000_0000;
    end
    else
    begin
      nv_rd <= boot == gpb_pkg::GPB_RESTORE && !rd_pend;
      nv_wr <= boot == gpb_pkg::GPB_RUN && wr_u && req_num <= gpb_pkg::USER_NV_LAST;
      nv_addr <= boot == gpb_pkg::GPB_RESTORE ? rst_idx : req_num;
      nv_wdata <= req_wdata;
    end
  end

  // interrupt configuration
  logic [31:0] tmr_per [3];
  logic [1:0] edge_sel [5];
  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      for (int i = 0; i < 3; i++)
        tmr_per[i] <= 32'h0000_0000;
      for (int i = 0; i < 5; i++)
        edge_sel[i] <= gpb_pkg::EDGE_OFF;
    end
    else if (wr_i)
    begin
      case (req_num)
        gpb_pkg::P_TMR0: tmr_per[0] <= req_wdata;
        gpb_pkg::P_TMR1: tmr_per[1] <= req_wdata;
        gpb_pkg::P_TMR2: tmr_per[2] <= req_wdata;
        gpb_pkg::P_STOPL: edge_sel[0] <= req_wdata[1:0];
        gpb_pkg::P_STOPR: edge_sel[1] <= req_wdata[1:0];
        gpb_pkg::P_IN0: edge_sel[2] <= req_wdata[1:0];
        gpb_pkg::P_IN1: edge_sel[3] <= req_wdata[1:0];
        gpb_pkg::P_IN2: edge_sel[4] <= req_wdata[1:0];
        default: ;
      endcase
    end
  end

  // timers and edge detectors set sticky pending bits
  logic [31:0] tmr_cnt [3];
  logic [4:0] in_now, in_prev;
  logic [7:0] pend; // 0..2 timers, 3..7 edge sources
  logic [7:0] hit;
  logic [7:0] take;
  assign in_now = {gp_in, stop_right, stop_left};
  always_comb
  begin
    hit = 8'h00;
    for (int i = 0; i < 3; i++)
      hit[i] = ms_tick && tmr_per[i] != 32'h0000_0000
        && tmr_cnt[i] + 32'h0000_0001 >= tmr_per[i];
    for (int i = 0; i < 5; i++)
      hit[i + 3] = (edge_sel[i][0] && in_now[i] && !in_prev[i])
        || (edge_sel[i][1] && !in_now[i] && in_prev[i]);
  end

  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      for (int i = 0; i < 3; i++)
        tmr_cnt[i] <= 32'h0000_0000;
      in_prev <= 5'h00;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
        if (hit[i] || tmr_per[i] == 32'h0000_0000)
          tmr_cnt[i] <= 32'h0000_0000;
        else if (ms_tick)
          tmr_cnt[i] <= tmr_cnt[i] + 32'h0000_0001;
      in_prev <= in_now;
    end
  end

  // lowest pending number issued first; new hits win over the clear
  always_comb
  begin
    take = 8'h00;
    for (int i = 7; i >= 0; i--)
      if (pend[i])
        take = 8'(1 << i);
  end

  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pend <= 8'h00;
      irq_valid <= 1'b0;
      irq_num <= 8'h00;
    end
    else
    begin
      pend <= (pend & ~take) | hit;
      irq_valid <= take != 8'h00;
      irq_num <= 8'h00;
      for (int i = 0; i < 3; i++)
        if (take[i])
          irq_num <= 8'(i);
      if (take[3]) irq_num <= gpb_pkg::P_STOPL;
      if (take[4]) irq_num <= gpb_pkg::P_STOPR;
      if (take[5]) irq_num <= gpb_pkg::P_IN0;
      if (take[6]) irq_num <= gpb_pkg::P_IN1;
      if (take[7]) irq_num <= gpb_pkg::P_IN2;
    end
  end

  // read mux, one cycle after the request
  logic [31:0] rd;
  logic rd_err;
  always_comb
  begin
    rd = 32'h0000_0000;
    rd_err = 1'b0;
    case (req_bank)
      gpb_pkg::BANK_GLOBAL:
        case (req_num)
          gpb_pkg::P_AUTORUN: rd = {31'h0, autorun};
          gpb_pkg::P_PROTECT: rd = {30'h0, protection};
          gpb_pkg::P_CAN_WD: rd = {16'h0, can_wd};
          gpb_pkg::P_CAN_ALT: rd = {21'h0, can_alt};
          gpb_pkg::P_COORD: rd = {31'h0, coord_persist};
          gpb_pkg::P_NORESTORE: rd = {31'h0, norestore};
          gpb_pkg::P_SER_ALT: rd = {24'h0, ser_alt};
          gpb_pkg::P_RUN_STATE: rd = {30'h0, run_state_in};
          gpb_pkg::P_LOAD_STATE: rd = {31'h0, load_state_in};
          gpb_pkg::P_IPTR: rd = iptr_in;
          gpb_pkg::P_MS_CNT: rd = ms_cnt;
          gpb_pkg::P_RANDOM: rd = {1'b0, seed[30:0] & gpb_pkg::RANDOM_MASK};
          gpb_pkg::P_MUTE: rd = {31'h0, mute};
          default: rd_err = 1'b1;
        endcase
      gpb_pkg::BANK_USER: rd = uvar[req_num];
      gpb_pkg::BANK_IRQ:
        case (req_num)
          gpb_pkg::P_TMR0: rd = tmr_per[0];
          gpb_pkg::P_TMR1: rd = tmr_per[1];
          gpb_pkg::P_TMR2: rd = tmr_per[2];
          gpb_pkg::P_STOPL: rd = {30'h0, edge_sel[0]};
          gpb_pkg::P_STOPR: rd = {30'h0, edge_sel[1]};
          gpb_pkg::P_IN0: rd = {30'h0, edge_sel[2]};
          gpb_pkg::P_IN1: rd = {30'h0, edge_sel[3]};
          gpb_pkg::P_IN2: rd = {30'h0, edge_sel[4]};
          default: rd_err = 1'b1;
        endcase
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 32'h0000_0000;
      rsp_error <= 1'b0;
    end
    else
    begin
      rsp_valid <= req_valid;
      rsp_rdata <= req_write ? 32'h0000_0000 : rd;
      rsp_error <= req_valid && rd_err;
    end
  end
endmodule

// ===== sim/gpb_global_param_bank_assertions.sv
// checker for the global parameter bank, watching only the top ports.
// assumes one clock domain and the async active-low reset on rst_n.
`timescale 1ns/10ps
module gpb_global_param_bank_assertions (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_bank,
  input wire logic [7:0] req_num,
  input wire logic [31:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_rdata,
  input wire logic rsp_error,
  input wire logic [7:0] cmd_opcode,
  input wire logic reply_enable,
  input wire logic [10:0] can_rx_id,
  input wire logic [7:0] ser_rx_addr,
  input wire logic can_alt_hit,
  input wire logic ser_alt_hit,
  input wire logic [31:0] iptr_in,
  input wire logic program_erase,
  input wire logic nv_rd,
  input wire logic nv_wr,
  input wire logic [7:0] nv_addr,
  input wire logic irq_valid,
  input wire logic [7:0] irq_num
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // bank 0 read strobes of interest
  logic rd0;
  logic wr_unprot;
  assign rd0 = req_valid && !req_write && req_bank == gpb_pkg::BANK_GLOBAL;
  // a write that drops disassembly protection is the only cause of an erase
  assign wr_unprot = req_valid && req_write && req_bank == gpb_pkg::BANK_GLOBAL
    && req_num == gpb_pkg::P_PROTECT && !req_wdata[gpb_pkg::PROT_DISASM_BIT];
  property p_rsp_timing;
    req_valid |=> rsp_valid;
  endproperty
  a_rsp_timing: assert property (p_rsp_timing) else $error("no answer after request");
  property p_rsp_cause;
    rsp_valid |-> $past(req_valid);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("answer without request");
  property p_err_zero;
    rsp_error |-> rsp_valid && rsp_rdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error answer carries data");
  property p_random;
    rd0 && req_num == gpb_pkg::P_RANDOM |=> rsp_valid && !rsp_rdata[31];
  endproperty
  a_random: assert property (p_random) else $error("random value out of range");
  property p_iptr;
    rd0 && req_num == gpb_pkg::P_IPTR |=> rsp_rdata == $past(iptr_in);
  endproperty
  a_iptr: assert property (p_iptr) else $error("pointer read mismatch");
  property p_mute;
    !reply_enable |-> !($past(cmd_opcode) inside {8'h06, 8'h0a, 8'h0f});
  endproperty
  a_mute: assert property (p_mute) else $error("read command reply muted");
  property p_can_alt;
    can_alt_hit |-> $past(can_rx_id) != 11'h0;
  endproperty
  a_can_alt: assert property (p_can_alt) else $error("zero can id matched");
  property p_ser_alt;
    ser_alt_hit |-> $past(ser_rx_addr) != 8'h0;
  endproperty
  a_ser_alt: assert property (p_ser_alt) else $error("zero serial addr matched");
  property p_erase;
    program_erase |-> $past(wr_unprot) || $past(wr_unprot, 2);
  endproperty
  a_erase: assert property (p_erase) else $error("erase without cause");
  property p_nv_scope;
    nv_rd || nv_wr |-> nv_addr <= gpb_pkg::USER_NV_LAST;
  endproperty
  a_nv_scope: assert property (p_nv_scope) else $error("nv access beyond 56");
  property p_irq_num;
    irq_valid |-> irq_num inside {8'h00, 8'h01, 8'h02, 8'h1b, 8'h1c, 8'h27, 8'h28, 8'h29};
  endproperty
  a_irq_num: assert property (p_irq_num) else $error("bad interrupt number");
  property p_boot_reply;
    $rose(rst_n) |-> reply_enable;
  endproperty
  a_boot_reply: assert property (p_boot_reply) else $error("muted at startup");
endmodule
bind gpb_global_param_bank gpb_global_param_bank_assertions u_gpb_global_param_bank_assertions (
  .core_clk, .rst_n, .req_valid, .req_write, .req_bank, .req_num, .req_wdata, .rsp_valid,
  .rsp_rdata, .rsp_error, .cmd_opcode, .reply_enable, .can_rx_id, .ser_rx_addr, .can_alt_hit,
  .ser_alt_hit, .iptr_in, .program_erase, .nv_rd, .nv_wr, .nv_addr, .irq_valid, .irq_num);

// ===== sim/gpb_nv_store.sv
// nonvolatile store model answering the bank's read and write pulses.
// assumes single-cycle nv_rd/nv_wr pulses; answers fast or slow by address.
`timescale 1ns/10ps
module gpb_nv_store (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic nv_rd,
  input wire logic nv_wr,
  input wire logic [7:0] nv_addr,
  input wire logic [31:0] nv_wdata,
  output logic nv_ready,
  output logic [31:0] nv_rdata
);
  logic [31:0] mem [0:255]; // preloaded pattern, lets restore be checked
  logic [7:0] a;
  int cnt;
  int n_rd; // completed reads since reset
  initial foreach (mem[i]) mem[i] = 32'ha5c3_0000 + i;
  // odd addresses answer slowly; data is scrambled once released
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      n_rd <= 0;
      cnt <= 0;
      nv_ready <= 1'b0;
      nv_rdata <= 32'h0;
    end
    else
    begin
      nv_ready <= 1'b0;
      if (nv_ready)
        nv_rdata <= ~nv_rdata;
      if (nv_wr)
        mem[nv_addr] <= nv_wdata;
      if (nv_rd)
      begin
        a <= nv_addr;
        cnt <= nv_addr[0] ? 4 : 1;
      end
      else if (cnt == 1)
      begin
        nv_ready <= 1'b1;
        nv_rdata <= mem[a];
        n_rd <= n_rd + 1;
        cnt <= 0;
      end
      else if (cnt > 1)
        cnt <= cnt - 1;
    end
  end
endmodule

// ===== sim/test_gpb_global_param_bank.sv
// testbench for the global parameter bank: parameter reads and writes.
// assumes the nv store model and the bound checker; inputs move on negedge.
`timescale 1ns/10ps
module test_gpb_global_param_bank;
  logic core_clk = 0, rst_n = 0, req_valid = 0, req_write = 0, rsp_valid, rsp_error;
  logic [1:0] req_bank = 0, run_state_in = 2'h2, protection;
  logic [7:0] req_num = 0, cmd_opcode = 0, ser_rx_addr = 0, irq_num, nv_addr;
  logic [31:0] req_wdata = 0, rsp_rdata, iptr_in = 32'h0000_1234, nv_rdata, nv_wdata, rd, r1;
  logic cmd_valid = 0, cmd_from_can = 0, load_state_in = 1, reply_enable, can_alt_hit;
  logic ser_alt_hit, program_start, program_erase, motor_stop, coord_persist, nv_ready;
  logic nv_wr, nv_rd, stop_left = 0, stop_right = 0, irq_valid, er;
  logic [10:0] can_rx_id = 0;
  logic [2:0] gp_in = 0;
  logic [7:0] q [$]; // interrupt numbers seen
  logic [9:0] ra [14] = '{10'h04d, 10'h052, 10'h053, 10'h054, 10'h055, 10'h057, 10'h300,
    10'h301, 10'h302, 10'h31b, 10'h31c, 10'h327, 10'h328, 10'h329};
  logic [31:0] rv [14] = '{32'h1, 32'h10, 32'h7ff, 32'h1, 32'h1, 32'hff, 32'hffff_ffff,
    32'h7, 32'h1, 32'h3, 32'h2, 32'h1, 32'h2, 32'h3};
  logic [1:0] pv [8] = '{2'h1, 2'h3, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h0};
  logic [7:0] ops [4] = '{8'h06, 8'h0a, 8'h0f, 8'h01};
  int fail_count = 0, n_compared = 0, n_erase = 0, n_start = 0, e0;
  logic [1:0] prev;
  gpb_global_param_bank u_gpb_global_param_bank (.*);
  gpb_nv_store u_gpb_nv_store (.*);
  always #4 core_clk = ~core_clk;
  // pulse counters and interrupt log, sampled mid-cycle where the pulses are settled
  always @(negedge core_clk)
  begin
    if (program_erase === 1'b1) n_erase++;
    if (program_start === 1'b1) n_start++;
    if (irq_valid === 1'b1) q.push_back(irq_num);
  end
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      fail_count++;
    end
  endtask
  // one request, held over the taking edge, answer looked at one cycle later
  task automatic acc(input logic w, input logic [1:0] b, input logic [7:0] n,
    input logic [31:0] d);
    int k;
    @(negedge core_clk);
    req_valid = 1;
    req_write = w;
    req_bank = b;
    req_num = n;
    req_wdata = d;
    @(negedge core_clk);
    req_valid = 0;
    for (k = 0; k < 4 && rsp_valid !== 1'b1; k++) @(negedge core_clk);
    if (rsp_valid !== 1'b1)
    begin
      fail_count++;
      summarize();
    end
    rd = rsp_rdata;
    er = rsp_error;
  endtask
  task automatic rdc(input logic [1:0] b, input logic [7:0] n, input logic [31:0] e);
    acc(0, b, n, 32'h0);
    chk(rd, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // reset, optionally set autorun while the restore runs, then wait for 56 words
  task automatic rst(input logic ar);
    int k;
    rst_n = 0;
    cyc(4);
    rst_n = 1;
    cyc(2);
    if (ar)
      acc(1, 0, 8'h4d, 1);
    for (k = 0; k < 3000 && u_gpb_nv_store.n_rd < 56; k++) @(negedge core_clk);
    if (u_gpb_nv_store.n_rd < 56)
      fail_count++;
    cyc(6);
  endtask
  initial
  begin
    cyc(20000);
    fail_count++;
    summarize();
  end
  initial
  begin
    rst(0);
    chk(reply_enable, 1);
    chk(motor_stop, 0);
    chk(n_start, 0);
    rdc(0, 8'h4d, 0);
    rdc(0, 8'h52, 0);
    rdc(0, 8'h55, 0);
    rdc(0, 8'hff, 0);
    rdc(2, 8'h05, 32'ha5c3_0005);
    rdc(2, 8'h37, 32'ha5c3_0037);
    foreach (ra[i])
    begin
      acc(1, ra[i][9:8], ra[i][7:0], rv[i]);
      rdc(ra[i][9:8], ra[i][7:0], rv[i]);
    end
    chk(coord_persist, 1);
    rdc(0, 8'h80, 2);
    rdc(0, 8'h81, 1);
    acc(1, 0, 8'h82, 32'h0);
    rdc(0, 8'h82, 32'h0000_1234);
    acc(0, 1, 8'h10, 0);
    chk({rd[30:0], er}, 1);
    prev = 0;
    foreach (pv[i])
    begin
      e0 = n_erase;
      acc(1, 0, 8'h51, {30'h0, pv[i]});
      cyc(2);
      chk(n_erase - e0, prev[0] & !pv[i][0]);
      chk(protection, pv[i]);
      prev = pv[i];
    end
    acc(1, 0, 8'h53, 32'h123);
    acc(1, 0, 8'h57, 32'h5a);
    can_rx_id = 11'h123;
    ser_rx_addr = 8'h5a;
    cyc(2);
    chk({can_alt_hit, ser_alt_hit}, 3);
    can_rx_id = 0;
    ser_rx_addr = 0;
    acc(1, 0, 8'h53, 32'h0);
    acc(1, 0, 8'h57, 32'h0);
    cyc(2);
    chk({can_alt_hit, ser_alt_hit}, 0);
    acc(1, 0, 8'hff, 1);
    foreach (ops[i])
    begin
      cmd_opcode = ops[i];
      cmd_valid = 1;
      cyc(1);
      cmd_valid = 0;
      cyc(1);
      chk(reply_enable, i < 3);
    end
    acc(0, 0, 8'h85, 0);
    r1 = rd;
    acc(0, 0, 8'h85, 0);
    chk({r1[31], rd[31], r1 == rd}, 0);
    acc(1, 0, 8'h84, 32'h7000_0000);
    rdc(0, 8'h84, 32'h7000_0000);
    // a persistent variable reaches the store, a volatile one does not
    acc(1, 2, 8'h03, 32'h1234_5678);
    acc(1, 2, 8'h40, 32'h0bad_0bad);
    cyc(1);
    chk(u_gpb_nv_store.mem[3], 32'h1234_5678);
    chk(u_gpb_nv_store.mem[64], 32'ha5c3_0040);
    rdc(2, 8'h40, 32'h0bad_0bad);
    for (int c = 0; c < 4; c++)
    begin
      acc(1, 3, 8'h27, c);
      q.delete();
      gp_in[0] = 1;
      cyc(6);
      gp_in[0] = 0;
      cyc(6);
      chk(q.size(), c[0] + c[1]);
    end
    acc(1, 3, 8'h1b, 1);
    acc(1, 3, 8'h27, 1);
    q.delete();
    stop_left = 1;
    gp_in[0] = 1;
    cyc(8);
    chk({16'(q.size()), q[0], q[1]}, 32'h0002_1b27);
    rst(1);
    rdc(0, 8'hff, 0);
    chk(n_start, 1);
    rdc(2, 8'h03, 32'h1234_5678);
    summarize();
  end
endmodule
